/* rtl/fhc_pkg.sv */
// fhc_pkg: constants, carriers and state types of the head and i/o control
package fhc_pkg;

   // =====================================================================
   // clock rate and timer width
   // =====================================================================
   localparam real CLK_MHZ = 25.0;
   localparam int TW = 24;

   // =====================================================================
   // times as printed, each in its own unit
   // =====================================================================
   localparam real SETTLE_MS = 18.0;
   localparam real SEEK_CMPL_MS = 15.8;
   localparam real UNLOAD_MS = 200.0;
   localparam real READY_MS = 480.0;
   localparam real T00_VALID_MS = 2.8;
   localparam real IDX_WIDTH_MS = 1.5;
   localparam real STEP_RATE_MS = 3.0;
   localparam real SIDE_US = 100.0;
   localparam real ERASE_HD_US = 650.0;
   localparam real ERASE_ND_US = 690.0;
   localparam real PB_WIDTH_US = 0.15;

   // =====================================================================
   // cycle counts derived from the times (least times round up)
   // =====================================================================
   localparam int SETTLE_CYC = int'($ceil(SETTLE_MS * 1000.0 * CLK_MHZ));
   localparam int SEEK_CMPL_CYC =
      int'($ceil(SEEK_CMPL_MS * 1000.0 * CLK_MHZ));
   localparam int UNLOAD_CYC = int'($ceil(UNLOAD_MS * 1000.0 * CLK_MHZ));
   localparam int READY_CYC = int'($ceil(READY_MS * 1000.0 * CLK_MHZ));
   localparam int T00_CYC = int'($ceil(T00_VALID_MS * 1000.0 * CLK_MHZ));
   localparam int IDX_CYC = int'($ceil(IDX_WIDTH_MS * 1000.0 * CLK_MHZ));
   localparam int RATE_CYC = int'($ceil(STEP_RATE_MS * 1000.0 * CLK_MHZ));
   localparam int SIDE_CYC = int'($ceil(SIDE_US * CLK_MHZ));
   localparam int ERASE_HD_CYC = int'($ceil(ERASE_HD_US * CLK_MHZ));
   localparam int ERASE_ND_CYC = int'($ceil(ERASE_ND_US * CLK_MHZ));
   localparam logic [2:0] PB_CYC = 3'(int'($ceil(PB_WIDTH_US * CLK_MHZ)));

   // =====================================================================
   // track limits
   // =====================================================================
   localparam logic [6:0] TRACK_ZERO = 7'h00;
   localparam logic [6:0] TRACK_LAST = 7'h51;

   // =====================================================================
   // register map and fields
   // =====================================================================
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STAT = 12'h004;
   localparam int CTRL_HD_BIT = 0;
   localparam logic CTRL_HD_RST = 1'h1;
   localparam int STAT_HEAD_LSB = 0;
   localparam int STAT_TRACK_LSB = 8;
   localparam int STAT_PEND_LSB = 16;
   localparam int STAT_UNLOAD_BIT = 24;
   localparam int STAT_RECAL_BIT = 25;
   localparam int STAT_READY_BIT = 26;
   localparam int STAT_SEEKC_BIT = 27;
   localparam int STAT_WMODE_BIT = 28;

   // =====================================================================
   // types
   // =====================================================================
   typedef enum logic [1:0] {EX_IDLE, EX_RECAL, EX_REPLAY} fhc_ex_t;

   typedef struct packed {
      logic unit_choose_n;
      logic spindle_run_n;
      logic seek_way;
      logic head_move_pulse_n;
      logic record_enable_n;
      logic record_pulse_n;
      logic surface_choice;
   } fhc_host_in_t;

   typedef struct packed {
      logic outer_cylinder_flag_n;
      logic revolution_mark_n;
      logic playback_pulse_n;
      logic ready_n;
   } fhc_host_out_t;

   typedef struct packed {
      logic disk_present;
      logic record_inhibit;
      logic track0_sensor;
      logic index_detect;
      logic read_detect;
   } fhc_mech_in_t;

   typedef struct packed {
      logic step;
      logic step_out;
      logic write_pulse;
      logic write_mode;
      logic side1_sel;
   } fhc_mech_out_t;

   typedef struct packed {
      logic hmp_n_prev;
      logic wen_prev;
      logic wp_n_prev;
      logic side_prev;
      logic spin_prev;
      logic idx_prev;
      logic rd_prev;
      fhc_ex_t ex;
      logic [6:0] head_pos;
      logic [6:0] track;
      logic signed [7:0] pend;
      logic idx_seen;
      logic ready;
      logic [2:0] pb_cnt;
      logic mode_hd;
      fhc_host_out_t host_out;
      fhc_mech_out_t mech_out;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } fhc_st_t;

endpackage : fhc_pkg

/* rtl/fhc_timer.sv */
// fhc_timer: reloadable down counter that flags when its interval ran out
`timescale 1ns/10ps
module fhc_timer #(
   parameter int W = 24
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [W-1:0] load,
   output logic done
);

   typedef struct packed {
      logic [W-1:0] cnt;
   } fhc_tmr_st_t;

   fhc_tmr_st_t q;
   fhc_tmr_st_t d;

   // =====================================================================
   // counting
   // =====================================================================
   // start reloads, otherwise count down to zero and rest there
   always_comb begin
      d = q;
      if (start) begin
         d.cnt = load;
      end else if (q.cnt != '0) begin
         d.cnt = q.cnt - W'(1);
      end
   end

   // comes up expired so that nothing waits after reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign done = (q.cnt == '0);

endmodule : fhc_timer

/* rtl/fhc_head_io.sv */
// fhc_head_io: head stepping, write qualification and read/index gating
`timescale 1ns/10ps
module fhc_head_io #(
   parameter int unsigned SETTLE_CYC = fhc_pkg::SETTLE_CYC,
   parameter int unsigned SEEK_CMPL_CYC = fhc_pkg::SEEK_CMPL_CYC,
   parameter int unsigned UNLOAD_CYC = fhc_pkg::UNLOAD_CYC,
   parameter int unsigned READY_CYC = fhc_pkg::READY_CYC,
   parameter int unsigned T00_CYC = fhc_pkg::T00_CYC,
   parameter int unsigned IDX_CYC = fhc_pkg::IDX_CYC,
   parameter int unsigned RATE_CYC = fhc_pkg::RATE_CYC,
   parameter int unsigned ERASE_HD_CYC = fhc_pkg::ERASE_HD_CYC,
   parameter int unsigned ERASE_ND_CYC = fhc_pkg::ERASE_ND_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire fhc_pkg::fhc_host_in_t host_in,
   output fhc_pkg::fhc_host_out_t host_out,
   input wire fhc_pkg::fhc_mech_in_t mech_in,
   output fhc_pkg::fhc_mech_out_t mech_out
);

   localparam int TW = fhc_pkg::TW;

   fhc_pkg::fhc_st_t q;
   fhc_pkg::fhc_st_t d;

   logic unit;
   logic spin;
   logic wen;
   logic step_edge;
   logic wp_fall;
   logic side_chg;
   logic spin_start;
   logic wen_fall;
   logic idx_rise;
   logic rd_rise;
   logic unloading;
   logic busy;
   logic flag_now;
   logic ignore;
   logic accept;
   logic rate_start;
   logic settle_done;
   logic seekc_done;
   logic unload_done;
   logic ready_done;
   logic t00_done;
   logic idx_done;
   logic rate_done;
   logic side_done;
   logic erase_done;
   logic [TW-1:0] erase_load;
   logic read_gate;
   logic [31:0] status;

   // =====================================================================
   // pin decoding and edges
   // =====================================================================
   // host pins are active low; edges are seen against last cycle's level
   assign unit = ~host_in.unit_choose_n;
   assign spin = ~host_in.spindle_run_n;
   assign wen = ~host_in.record_enable_n;
   assign step_edge = ~q.hmp_n_prev & host_in.head_move_pulse_n;
   assign wp_fall = q.wp_n_prev & ~host_in.record_pulse_n;
   assign side_chg = q.side_prev != host_in.surface_choice;
   assign spin_start = spin & ~q.spin_prev;
   assign wen_fall = q.wen_prev & ~wen;
   assign idx_rise = mech_in.index_detect & ~q.idx_prev;
   assign rd_rise = mech_in.read_detect & ~q.rd_prev;

   // =====================================================================
   // step qualification
   // =====================================================================
   // spindle counts as running one cycle after the pin, when its timer
   // has already been loaded
   assign unloading = ~mech_in.disk_present | ~q.spin_prev
      | ~unload_done;
   assign busy = unloading | (q.ex != fhc_pkg::EX_IDLE);
   assign flag_now = ~q.host_out.outer_cylinder_flag_n;
   assign ignore = (wen & ~mech_in.record_inhibit)
      | (flag_now & host_in.seek_way)
      | (~host_in.seek_way & (q.track == fhc_pkg::TRACK_LAST));
   assign accept = step_edge & unit & ~ignore;

   // =====================================================================
   // interval timers
   // =====================================================================
   // erase delay depends on the density mode chosen by software
   assign erase_load = q.mode_hd ? TW'(ERASE_HD_CYC) : TW'(ERASE_ND_CYC);

   fhc_timer #(.W(TW)) u_settle (
      .clk(pclk), .rst_n(presetn), .start(accept),
      .load(TW'(SETTLE_CYC)), .done(settle_done));
   fhc_timer #(.W(TW)) u_seekc (
      .clk(pclk), .rst_n(presetn), .start(accept),
      .load(TW'(SEEK_CMPL_CYC)), .done(seekc_done));
   fhc_timer #(.W(TW)) u_unload (
      .clk(pclk), .rst_n(presetn), .start(spin_start),
      .load(TW'(UNLOAD_CYC)), .done(unload_done));
   fhc_timer #(.W(TW)) u_ready (
      .clk(pclk), .rst_n(presetn), .start(spin_start),
      .load(TW'(READY_CYC)), .done(ready_done));
   fhc_timer #(.W(TW)) u_t00 (
      .clk(pclk), .rst_n(presetn), .start(accept),
      .load(TW'(T00_CYC)), .done(t00_done));
   fhc_timer #(.W(TW)) u_idx (
      .clk(pclk), .rst_n(presetn), .start(idx_rise),
      .load(TW'(IDX_CYC)), .done(idx_done));
   fhc_timer #(.W(TW)) u_rate (
      .clk(pclk), .rst_n(presetn), .start(rate_start),
      .load(TW'(RATE_CYC)), .done(rate_done));
   fhc_timer #(.W(TW)) u_side (
      .clk(pclk), .rst_n(presetn), .start(side_chg),
      .load(TW'(fhc_pkg::SIDE_CYC)), .done(side_done));
   fhc_timer #(.W(TW)) u_erase (
      .clk(pclk), .rst_n(presetn), .start(wen_fall),
      .load(erase_load), .done(erase_done));

   // =====================================================================
   // read gating and status word
   // =====================================================================
   // wen_prev blocks the fall cycle itself, before the erase timer loads
   assign read_gate = unit & q.ready & seekc_done & ~wen & ~q.wen_prev
      & erase_done & settle_done & side_done;

   always_comb begin
      status = '0;
      status[fhc_pkg::STAT_HEAD_LSB +: 7] = q.head_pos;
      status[fhc_pkg::STAT_TRACK_LSB +: 7] = q.track;
      status[fhc_pkg::STAT_PEND_LSB +: 8] = q.pend;
      status[fhc_pkg::STAT_UNLOAD_BIT] = unloading;
      status[fhc_pkg::STAT_RECAL_BIT] = q.ex == fhc_pkg::EX_RECAL;
      status[fhc_pkg::STAT_READY_BIT] = q.ready;
      status[fhc_pkg::STAT_SEEKC_BIT] = seekc_done;
      status[fhc_pkg::STAT_WMODE_BIT] = q.mech_out.write_mode;
   end

   // =====================================================================
   // next state
   // =====================================================================
   always_comb begin
      d = q;
      rate_start = 1'b0;
      d.hmp_n_prev = host_in.head_move_pulse_n;
      d.wen_prev = wen;
      d.wp_n_prev = host_in.record_pulse_n;
      d.side_prev = host_in.surface_choice;
      d.spin_prev = spin;
      d.idx_prev = mech_in.index_detect;
      d.rd_prev = mech_in.read_detect;
      d.mech_out.step = 1'b0;

      // accepted step: move at once when idle, else only count it
      if (accept) begin
         d.mech_out.step_out = host_in.seek_way;
         if (host_in.seek_way) begin
            if (q.track != fhc_pkg::TRACK_ZERO) begin
               d.track = q.track - 7'h01;
            end
         end else begin
            d.track = q.track + 7'h01;
         end
         if (busy) begin
            d.pend = host_in.seek_way ? q.pend - 8'sh01 : q.pend + 8'sh01;
         end else begin
            d.mech_out.step = 1'b1;
            if (host_in.seek_way) begin
               if (q.head_pos != fhc_pkg::TRACK_ZERO) begin
                  d.head_pos = q.head_pos - 7'h01;
               end
            end else begin
               d.head_pos = q.head_pos + 7'h01;
            end
         end
      end

      // deferred head movement once loading is complete
      case (q.ex)
         fhc_pkg::EX_RECAL: begin
            if (!unloading) begin
               if (mech_in.track0_sensor) begin
                  d.head_pos = fhc_pkg::TRACK_ZERO;
                  d.track = fhc_pkg::TRACK_ZERO;
                  d.ex = fhc_pkg::EX_REPLAY;
                  rate_start = 1'b1;
               end else if (rate_done) begin
                  d.mech_out.step = 1'b1;
                  d.mech_out.step_out = 1'b1;
                  rate_start = 1'b1;
               end
            end
         end
         fhc_pkg::EX_REPLAY: begin
            if (!unloading && rate_done) begin
               if (q.pend == 8'sh00) begin
                  d.ex = fhc_pkg::EX_IDLE;
                  d.track = q.head_pos;
               end else begin
                  d.mech_out.step = 1'b1;
                  d.mech_out.step_out = q.pend[7];
                  rate_start = 1'b1;
                  if (q.pend[7]) begin
                     d.pend = q.pend + 8'sh01;
                     if (q.head_pos != fhc_pkg::TRACK_ZERO) begin
                        d.head_pos = q.head_pos - 7'h01;
                     end
                  end else begin
                     d.pend = q.pend - 8'sh01;
                     d.head_pos = q.head_pos + 7'h01;
                  end
               end
            end
         end
         fhc_pkg::EX_IDLE: begin
            if (!unloading && q.pend != 8'sh00) begin
               d.ex = fhc_pkg::EX_REPLAY;
               rate_start = 1'b1;
            end
         end
         default: begin
            d.ex = fhc_pkg::EX_RECAL;
         end
      endcase

      // outer track flag: counter while unloading, sensor during recal, head otherwise
      if (t00_done) begin
         if (unloading) begin
            d.host_out.outer_cylinder_flag_n =
               q.track != fhc_pkg::TRACK_ZERO;
         end else if (q.ex == fhc_pkg::EX_RECAL) begin
            d.host_out.outer_cylinder_flag_n = ~mech_in.track0_sensor;
         end else begin
            d.host_out.outer_cylinder_flag_n =
               q.head_pos != fhc_pkg::TRACK_ZERO;
         end
      end

      // ready state: disk, spindle long enough, index seen since start
      if (spin_start) begin
         d.idx_seen = 1'b0;
      end else if (idx_rise && q.spin_prev) begin
         d.idx_seen = 1'b1;
      end
      d.ready = mech_in.disk_present & q.spin_prev & ready_done
         & q.idx_seen;
      d.host_out.ready_n = ~d.ready;

      // index pulse window gated by unit, ready and seek complete
      d.host_out.revolution_mark_n = ~(~idx_done & unit & q.ready
         & seekc_done);

      // playback pulse stretched to its least width
      if (rd_rise && read_gate) begin
         d.pb_cnt = fhc_pkg::PB_CYC;
      end else if (q.pb_cnt != 3'h0) begin
         d.pb_cnt = q.pb_cnt - 3'h1;
      end
      d.host_out.playback_pulse_n = d.pb_cnt == 3'h0;

      // write path and head select
      d.mech_out.write_mode = wen & unit & ~mech_in.record_inhibit;
      d.mech_out.write_pulse = wp_fall & wen
         & ~mech_in.record_inhibit;
      d.mech_out.side1_sel = ~host_in.surface_choice;

      // apb slave: answer one cycle into the access phase
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      if (psel && penable && !q.pready) begin
         d.pready = 1'b1;
         case (paddr)
            fhc_pkg::ADDR_CTRL: begin
               d.prdata = {31'h0, q.mode_hd};
            end
            fhc_pkg::ADDR_STAT: begin
               d.prdata = status;
            end
            default: begin
               d.prdata = 32'h0;
               d.pslverr = 1'b1;
            end
         endcase
      end
      if (psel && penable && q.pready && pwrite
         && paddr == fhc_pkg::ADDR_CTRL) begin
         d.mode_hd = pwdata[fhc_pkg::CTRL_HD_BIT];
      end
   end

   // =====================================================================
   // state register
   // =====================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.hmp_n_prev <= 1'b1;
         q.wp_n_prev <= 1'b1;
         q.side_prev <= 1'b1; // idle pin level, no false surface change
         q.ex <= fhc_pkg::EX_RECAL;
         q.mode_hd <= fhc_pkg::CTRL_HD_RST;
         q.host_out <= '1;
      end else begin
         q <= d;
      end
   end

   // =====================================================================
   // outputs
   // =====================================================================
   assign host_out = q.host_out;
   assign mech_out = q.mech_out;
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;

endmodule : fhc_head_io

/* dv/fhc_head_io_monitor.sv */
// fhc_head_io_monitor: port-level assertions for the head and i/o control
`timescale 1ns/10ps
module fhc_head_io_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire fhc_pkg::fhc_host_in_t host_in,
   input wire fhc_pkg::fhc_host_out_t host_out,
   input wire fhc_pkg::fhc_mech_in_t mech_in,
   input wire fhc_pkg::fhc_mech_out_t mech_out
);
   // one clock domain, reset disables everything
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ==========
   // head and write path
   // ==========
   a_step_single: assert property (
      mech_out.step |=> !mech_out.step)
      else $error("step pulse longer than one cycle");
   a_wmode_cause: assert property (
      mech_out.write_mode == (!$past(host_in.record_enable_n)
      && !$past(host_in.unit_choose_n) && !$past(mech_in.record_inhibit)))
      else $error("write mode does not follow its qualifiers");
   a_wpulse_gate: assert property (
      mech_out.write_pulse |-> !$past(host_in.record_enable_n)
      && !$past(mech_in.record_inhibit) && !$past(host_in.record_pulse_n)
      && $past(host_in.record_pulse_n, 2))
      else $error("write pulse without enabled leading edge");
   a_wpulse_lead: assert property (
      !host_in.record_enable_n && !mech_in.record_inhibit
      && $fell(host_in.record_pulse_n) |=> mech_out.write_pulse)
      else $error("leading edge of write data lost");
   a_side_map: assert property (
      $stable(host_in.surface_choice) [*3]
      |-> mech_out.side1_sel != host_in.surface_choice)
      else $error("wrong head for surface choice");

   // ==========
   // read, index and ready
   // ==========
   a_pb_width: assert property (
      $fell(host_out.playback_pulse_n) |=> !host_out.playback_pulse_n [*3]
      ##1 host_out.playback_pulse_n)
      else $error("playback pulse not four cycles");
   a_pb_gate: assert property (
      $fell(host_out.playback_pulse_n) |-> $past(host_in.record_enable_n)
      && !$past(host_in.unit_choose_n) && !$past(host_out.ready_n))
      else $error("playback pulse outside its gate");
   a_mark_gate: assert property (
      !host_out.revolution_mark_n |-> !$past(host_in.unit_choose_n)
      && (!host_out.ready_n || !$past(host_out.ready_n)))
      else $error("revolution mark outside its gate");
   a_ready_cause: assert property (
      !host_out.ready_n |-> !$past(host_in.spindle_run_n, 4)
      && $past(mech_in.disk_present, 4))
      else $error("ready without disk and spindle");

   // ==========
   // register bus
   // ==========
   a_apb_answer: assert property (
      $rose(penable) && psel |=> pready ##1 !pready)
      else $error("apb answer not one wait state");
   a_apb_error: assert property (
      pslverr |-> pready && paddr != fhc_pkg::ADDR_CTRL
      && paddr != fhc_pkg::ADDR_STAT)
      else $error("error on a mapped address");
endmodule : fhc_head_io_monitor

bind fhc_head_io fhc_head_io_monitor u_mon (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .host_in(host_in), .host_out(host_out), .mech_in(mech_in),
   .mech_out(mech_out));

/* dv/fhc_host_model.sv */
// fhc_host_model: host controller model driving the drive control inputs
`timescale 1ns/10ps
module fhc_host_model #(
   parameter int SETTLE = 40, // the bench's shortened settle time
   parameter int HOLD = 10
) (
   input wire logic pclk,
   output fhc_pkg::fhc_host_in_t host_in
);
   // idle: unit on, spindle off, no pulses, lower head
   initial host_in = 7'h2F;

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   // level inputs set together
   task automatic level(input logic run, input logic sel, input logic surf,
      input logic wen);
      host_in.spindle_run_n <= !run;
      host_in.unit_choose_n <= !sel;
      host_in.surface_choice <= surf;
      host_in.record_enable_n <= !wen;
      cyc(2);
   endtask : level

   // one step: direction first, 0.8 us low, then spacing
   task automatic step(input logic out);
      host_in.seek_way <= out;
      cyc(1);
      host_in.head_move_pulse_n <= 1'b0;
      cyc(20);
      host_in.head_move_pulse_n <= 1'b1;
      cyc(12);
   endtask : step

   // write burst: settle first, pulse, then hold everything
   task automatic write(input logic en, input int n);
      cyc(SETTLE + fhc_pkg::SIDE_CYC);
      host_in.record_enable_n <= !en;
      cyc(2);
      repeat (n) begin
         host_in.record_pulse_n <= 1'b0;
         cyc(6);
         host_in.record_pulse_n <= 1'b1;
         cyc(6);
      end
      host_in.record_enable_n <= 1'b1;
      cyc(HOLD);
   endtask : write
endmodule : fhc_host_model

/* dv/tb.sv */
// tb: self-checking bench for the head and i/o control
`timescale 1ns/10ps
module tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, q;
   logic pready, pslverr, e;
   fhc_pkg::fhc_host_in_t host_in;
   fhc_pkg::fhc_host_out_t host_out;
   fhc_pkg::fhc_mech_in_t mech_in;
   fhc_pkg::fhc_mech_out_t mech_out;
   logic disk = 1'b0, inh = 1'b0, idx = 1'b0, rd = 1'b0;
   logic [6:0] phys = 7'h00;
   int nstep = 0, nwp = 0, npb = 0, nrev = 0;
   int fail_count = 0, check_count = 0;
   int seed = 32'h4c8e81da;

   assign mech_in = '{disk, inh, phys == 7'h00, idx, rd};

   // erase delays keep their real lengths; the read test spaces for them
   fhc_head_io #(.SETTLE_CYC(40), .SEEK_CMPL_CYC(35), .UNLOAD_CYC(20),
      .READY_CYC(30), .T00_CYC(8), .IDX_CYC(6), .RATE_CYC(5)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .host_in(host_in),
      .host_out(host_out), .mech_in(mech_in), .mech_out(mech_out));
   fhc_host_model host (.pclk(pclk), .host_in(host_in));

   always #20 pclk = ~pclk;

   // disk index once per revolution
   always begin
      repeat (198) @(posedge pclk);
      idx <= 1'b1;
      repeat (2) @(posedge pclk);
      idx <= 1'b0;
   end

   // mechanism: follow the head, count outgoing pulses
   always @(posedge pclk) begin
      if (mech_out.step)
         phys <= mech_out.step_out ? phys - 7'h01 : phys + 7'h01;
      nstep <= nstep + int'(mech_out.step);
      nwp <= nwp + int'(mech_out.write_pulse);
      npb <= npb + int'($fell(host_out.playback_pulse_n));
      nrev <= nrev + int'($fell(host_out.revolution_mark_n));
   end

   function automatic int wexp(input logic en, input logic prot, int n);
      return (en && !prot) ? n : 0;
   endfunction : wexp

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge, so a following call never re-raises psel at once
      @(posedge pclk);
   endtask : apb

   task automatic rdp(input int gap);
      rd <= 1'b1;
      repeat (2) @(posedge pclk);
      rd <= 1'b0;
      repeat (gap) @(posedge pclk);
   endtask : rdp

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run

   // watchdog against a hang
   initial begin
      repeat (90000) @(posedge pclk);
      fail_count++;
      complete_run();
   end

   // main sequence
   initial begin
      int n, s;
      phys = 7'(1 + {$random(seed)} % 5);
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, fhc_pkg::ADDR_CTRL, 32'h0);
      chk(q, 32'h1);
      apb(1'b1, 12'h0F0, 32'hFFFFFFFF);
      chk(32'(e), 32'h1);
      $display("test registers done");
      // stored steps while unloaded, then recal and replay
      repeat (3) host.step(1'b0);
      chk(nstep, 0);
      apb(1'b0, fhc_pkg::ADDR_STAT, 32'h0);
      chk(32'(q[23:16]), 32'h3);
      chk(32'(host_out.ready_n), 32'h1);
      s = 32'(phys);
      disk <= 1'b1;
      host.level(1'b1, 1'b1, 1'b1, 1'b0);
      n = 0;
      do begin
         apb(1'b0, fhc_pkg::ADDR_STAT, 32'h0);
         n++;
      end while ((q[25] | q[24] | (|q[23:16])) !== 1'b0 && n < 200);
      // replay idles and resyncs the track in the same cycle, one rate interval after its last step
      repeat (8) @(posedge pclk);
      apb(1'b0, fhc_pkg::ADDR_STAT, 32'h0);
      chk(32'(phys), 32'h3);
      chk(nstep, s + 3);
      chk(32'(q[14:8]), 32'h3);
      repeat (250) @(posedge pclk);
      chk(32'(host_out.ready_n), 32'h0);
      $display("test load done");
      // loaded steps in, back out, limits ignored
      n = 1 + {$random(seed)} % 4;
      repeat (n) host.step(1'b0);
      chk(32'(phys), 3 + n);
      repeat (3 + n) host.step(1'b1);
      chk(32'(phys), 32'h0);
      chk(32'(host_out.outer_cylinder_flag_n), 32'h0);
      s = nstep;
      host.step(1'b1);
      chk(nstep, s);
      repeat (81) host.step(1'b0);
      host.level(1'b1, 1'b1, 1'b1, 1'b1);
      host.step(1'b1);
      host.level(1'b1, 1'b1, 1'b1, 1'b0);
      host.step(1'b0);
      chk(32'(phys), 32'd81);
      $display("test steps done");
      // surface choice picks the head
      for (int i = 0; i < 2; i++) begin
         host.level(1'b1, 1'b1, i[0], 1'b0);
         chk(32'(mech_out.side1_sel), 32'(!i[0]));
      end
      // write pulses over enable and protect
      for (int i = 0; i < 4; i++) begin
         inh <= i[1];
         s = nwp;
         n = 1 + {$random(seed)} % 4;
         host.write(i[0], n);
         chk(nwp - s, wexp(i[0], i[1], n));
      end
      inh <= 1'b0;
      // playback only after the erase delay of each density mode
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, fhc_pkg::ADDR_CTRL, 32'(i));
         s = npb;
         host.write(1'b1, 0);
         // third pulse lands between the two erase delays, fourth after both
         rdp(13);
         rdp((fhc_pkg::ERASE_HD_CYC + fhc_pkg::ERASE_ND_CYC) / 2);
         rdp(fhc_pkg::ERASE_ND_CYC - fhc_pkg::ERASE_HD_CYC);
         rdp(6);
         chk(npb - s, 1 + i);
      end
      $display("test write read done");
      // revolution marks only while selected
      for (int i = 0; i < 2; i++) begin
         host.level(1'b1, i[0], 1'b1, 1'b0);
         s = nrev;
         repeat (400) @(posedge pclk);
         chk(32'(nrev > s), 32'(i));
      end
      host.level(1'b0, 1'b1, 1'b1, 1'b0);
      repeat (10) @(posedge pclk);
      chk(32'(host_out.ready_n), 32'h1);
      $display("test index done");
      complete_run();
   end
endmodule : tb
